// >>> design/skew_window.sv
// Timer that holds a window open for a set number of cycles after a start pulse.
`timescale 1ns/1ns
module skew_window #(
   parameter int CYC = 1000
) (
   input  wire logic clk,
   input  wire logic rstN,
   input  wire logic start,
   input  wire logic cancel,
   output logic      open
);
   localparam int CW = $clog2(CYC + 1);
   logic [CW-1:0] cnt_r;   // Cycles left in the window.
   initial begin
      if (CYC < 1) $error("skew_window needs at least one cycle.");
   end
   // =============================================================
   // Countdown; a fresh start reloads, cancel closes at once.
   // =============================================================
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cnt_r <= '0;
      end else if (start) begin
         cnt_r <= CW'(CYC);
      end else if (cancel) begin
         cnt_r <= '0;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
   assign open = (cnt_r != '0);
endmodule

// >>> design/term_decoder.sv
// Drive terminal command decoder: presets, ramps, run hold, alarms, jog and motor select.
`timescale 1ns/1ns
`include "term_decoder_cfg.svh"
module term_decoder
   import term_decoder_pkg::*;
#(
   parameter int FREQ_W   = `FREQ_WIDTH,
   parameter int SKEW_CYC = `JOG_SKEW_CYC
) (
   input  wire logic                  sys_clk,
   input  wire logic                  arst_n,
   input  wire logic [`FN_COUNT-1:0]  termPin,
   input  wire logic                  runForwardPin,
   input  wire logic                  runReversePin,
   input  wire logic                  keyJogPin,
   input  wire logic                  keyRunPin,
   input  wire logic [`FN_COUNT-1:0]  funcAssigned,
   input  wire logic [`FN_COUNT-1:0]  funcActiveLow,
   input  wire logic                  runSourceDigital,
   input  wire logic                  driveStopped,
   input  wire logic [FREQ_W-1:0]     presetFreq [1:`PRESET_COUNT],
   input  wire logic [FREQ_W-1:0]     freqSourceOne,
   input  wire logic [FREQ_W-1:0]     freqSourceTwo,
   input  wire logic [FREQ_W-1:0]     jogFrequency,
   input  wire ramp_t                 rampOne,
   input  wire ramp_t                 rampTwo,
   input  wire ramp_t                 jogRamp,
   output logic      [FREQ_W-1:0]     freqRef,
   output ramp_t                      rampActive,
   output run_cmd_t                   runCmd,
   output logic                       outputEnable,
   output logic                       faultAlarmOut,
   output logic      [`CODE_WIDTH-1:0] alarmCode,
   output logic                       alarmHold,
   output logic                       jogReady,
   output logic                       jogActive,
   output logic                       motorSelect,
   output logic                       motor2ActiveOut
);
   initial begin
      if (FREQ_W < 1 || FREQ_W > 32) $error("term_decoder FREQ_W out of range.");
      if (SKEW_CYC < 1) $error("term_decoder SKEW_CYC must be at least one.");
   end
   // =============================================================
   // Reset release
   // =============================================================
   logic [1:0] rstSync;   // Release synchroniser; assert stays asynchronous.
   logic       rstN;      // Reset used by the rest of the block.
   // Two stages so every flop leaves reset on the same edge.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   // =============================================================
   // Input synchronisation and polarity
   // =============================================================
   logic [`PIN_COUNT-1:0] pinLvl;   // Synchronised pin levels.
   logic [`FN_COUNT-1:0]  fnOn;     // Decoded function states.
   term_sync #(.W(`PIN_COUNT)) i_term_sync (
      .clk   (sys_clk),
      .rstN  (rstN),
      .raw   ({keyRunPin, keyJogPin, runReversePin, runForwardPin, termPin}),
      .level (pinLvl)
   );
   logic [`SYNC_SETTLE-1:0] warm_r;   // Fills after release; reset zeros would fake a trip.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         warm_r <= '0;
      end else begin
         warm_r <= {warm_r[`SYNC_SETTLE-2:0], 1'b1};
      end
   end
   // An unassigned function reads as off, which gives each default set.
   // The inversion bit also covers trip's fail-safe code.
   assign fnOn = (pinLvl[`FN_COUNT-1:0] ^ funcActiveLow) & funcAssigned
                 & {`FN_COUNT{warm_r[`SYNC_SETTLE-1]}};

   logic [3:0] presetIdx;     // Preset index, weights 1, 2, 4, 8.
   logic       fwdLvl, revLvl, keyJog, keyRun;
   logic       holdOn, coastOn, rstOn, tripOn, jogIn;
   assign presetIdx = fnOn[`FN_PRESET3:`FN_PRESET0];
   assign holdOn    = fnOn[`FN_HOLD];
   assign coastOn   = fnOn[`FN_COAST];
   assign rstOn     = fnOn[`FN_ALMRST];
   assign tripOn    = fnOn[`FN_TRIP];
   assign jogIn     = fnOn[`FN_JOG];
   assign fwdLvl    = pinLvl[`PIN_FWD];
   assign revLvl    = pinLvl[`PIN_REV];
   assign keyJog    = pinLvl[`PIN_KEYJOG];
   assign keyRun    = pinLvl[`PIN_KEYRUN];

   // Previous values for edge detection; all on the system clock.
   logic fwdPrev_r, revPrev_r, rstPrev_r, jogPrev_r, keyJogPrev_r;
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         fwdPrev_r    <= 1'b0;
         revPrev_r    <= 1'b0;
         rstPrev_r    <= 1'b0;
         jogPrev_r    <= 1'b0;
         keyJogPrev_r <= 1'b0;
      end else begin
         fwdPrev_r    <= fwdLvl;
         revPrev_r    <= revLvl;
         rstPrev_r    <= rstOn;
         jogPrev_r    <= jogIn;
         keyJogPrev_r <= keyJog;
      end
   end
   logic fwdRise, revRise, rstRise, rstFall, jogRise, keyJogRise;
   assign fwdRise    = fwdLvl & ~fwdPrev_r;
   assign revRise    = revLvl & ~revPrev_r;
   assign rstRise    = rstOn & ~rstPrev_r;
   assign rstFall    = ~rstOn & rstPrev_r;
   assign jogRise    = jogIn & ~jogPrev_r;
   assign keyJogRise = keyJog & ~keyJogPrev_r;

   // =============================================================
   // Three-wire self hold
   // =============================================================
   logic fwdHeld_r, revHeld_r;   // Self-held run commands.
   // Only the first edge is held; a later edge waits for hold to drop.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         fwdHeld_r <= 1'b0;
         revHeld_r <= 1'b0;
      end else if (!holdOn) begin
         fwdHeld_r <= 1'b0;
         revHeld_r <= 1'b0;
      end else if (!fwdHeld_r && !revHeld_r) begin
         fwdHeld_r <= fwdRise;
         revHeld_r <= revRise & ~fwdRise;
      end
   end
   logic runFwd, runRev;   // Effective run levels after holding.
   assign runFwd = fwdLvl | fwdHeld_r;
   assign runRev = revLvl | revHeld_r;

   // =============================================================
   // External trip and alarm reset
   // =============================================================
   logic tripLatch_r;   // Trip stays latched through an input recovery.
   // A trip still present when reset rises wins over the clear.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         tripLatch_r <= 1'b0;
      end else if (tripOn) begin
         tripLatch_r <= 1'b1;
      end else if (rstRise) begin
         tripLatch_r <= 1'b0;
      end
   end
   // Alarm relay drops on the reset's rising edge; display and hold
   // clear only on its falling edge so the operator sees the cause.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         faultAlarmOut <= 1'b0;
         alarmCode     <= `CODE_NONE;
         alarmHold     <= 1'b0;
      end else begin
         if (tripOn) begin
            faultAlarmOut <= 1'b1;
            alarmCode     <= `CODE_EXT_TRIP;
            alarmHold     <= 1'b1;
         end else begin
            if (rstRise) begin
               faultAlarmOut <= 1'b0;
            end
            if (rstFall) begin
               alarmCode <= `CODE_NONE;
               alarmHold <= 1'b0;
            end
         end
      end
   end

   // =============================================================
   // Jog readiness and jogging
   // =============================================================
   logic       keyToggle_r;   // Keypad-requested jog readiness.
   logic       skewOpen;      // Run arrived recently without jog.
   jog_state_t jogState_r;
   // The keypad toggle is dead under digital run source.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         keyToggle_r <= 1'b0;
      end else if (runSourceDigital || jogIn) begin
         keyToggle_r <= 1'b0;
      end else if (keyJogRise && driveStopped) begin
         keyToggle_r <= ~keyToggle_r;
      end
   end
   // Window after a bare run edge in which a late jog still counts.
   skew_window #(.CYC(SKEW_CYC)) i_skew_window (
      .clk    (sys_clk),
      .rstN   (rstN),
      .start  ((fwdRise | revRise) && jogState_r == JS_NORMAL && !jogIn),
      .cancel (jogIn),
      .open   (skewOpen)
   );
   logic wantReady, jogRun, lateJog;
   assign wantReady = jogIn | keyToggle_r;
   // Run pins start any jog; the run key only under keypad run source.
   assign jogRun  = fwdLvl | revLvl | (keyRun & ~runSourceDigital);
   assign lateJog = jogRise & skewOpen;
   // Mode changes only at standstill, except a jog inside the skew.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         jogState_r <= JS_NORMAL;
      end else begin
         case (jogState_r)
            JS_NORMAL: begin
               if (lateJog) begin
                  jogState_r <= JS_JOGGING;
               end else if (wantReady && driveStopped) begin
                  jogState_r <= JS_READY;
               end
            end
            JS_READY: begin
               if (!wantReady && driveStopped) begin
                  jogState_r <= JS_NORMAL;
               end else if (jogRun) begin
                  jogState_r <= JS_JOGGING;
               end
            end
            JS_JOGGING: begin
               if (!jogRun) begin
                  jogState_r <= JS_READY;
               end
            end
            default: begin
               jogState_r <= JS_NORMAL;
            end
         endcase
      end
   end

   // =============================================================
   // Run command and output enable
   // =============================================================
   // In ready state only a jog runs; a run that beat the jog
   // keeps running normally unless jog arrives inside the skew window.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         runCmd       <= '0;
         outputEnable <= 1'b0;
         jogReady     <= 1'b0;
         jogActive    <= 1'b0;
      end else begin
         jogReady  <= (jogState_r != JS_NORMAL);
         jogActive <= (jogState_r == JS_JOGGING);
         if (jogState_r == JS_READY) begin
            runCmd <= '0;
         end else if (jogState_r == JS_JOGGING) begin
            runCmd.run_forward <= fwdLvl | (keyRun & ~runSourceDigital & ~revLvl);
            runCmd.run_reverse <= revLvl;
         end else begin
            runCmd.run_forward <= runFwd;
            runCmd.run_reverse <= runRev & ~runFwd;
         end
         outputEnable <= ~coastOn & ~tripOn & ~tripLatch_r;
      end
   end

   // =============================================================
   // Frequency and ramp selection
   // =============================================================
   logic [FREQ_W-1:0] baseFreq;   // Ordinary source before presets.
   assign baseFreq = fnOn[`FN_FREQSEL] ? freqSourceTwo : freqSourceOne;
   // Jog values override both presets and normal ramps.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         freqRef    <= '0;
         rampActive <= '0;
      end else if (jogState_r == JS_JOGGING) begin
         freqRef    <= jogFrequency;
         rampActive <= jogRamp;
      end else begin
         if (presetIdx == 4'h0) begin
            freqRef <= baseFreq;
         end else begin
            freqRef <= presetFreq[presetIdx];
         end
         rampActive <= fnOn[`FN_RAMP] ? rampTwo : rampOne;
      end
   end

   // =============================================================
   // Motor selection
   // =============================================================
   // The completion output trails the switch by one cycle.
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         motorSelect     <= `MOTOR_RESET;
         motor2ActiveOut <= `MOTOR_RESET;
      end else begin
         if (driveStopped) begin
            motorSelect <= fnOn[`FN_MOTORSEL];
         end
         motor2ActiveOut <= motorSelect;
      end
   end

   // =============================================================
   // Checks
   // =============================================================
   a_trip_alarm: assert property (@(posedge sys_clk) disable iff (!rstN)
      tripOn |=> faultAlarmOut && !outputEnable && alarmCode == `CODE_EXT_TRIP)
      else $error("Trip did not raise alarm and stop output.");
   a_trip_latch: assert property (@(posedge sys_clk) disable iff (!rstN)
      tripLatch_r && !rstRise |=> tripLatch_r)
      else $error("Trip latch dropped without alarm reset.");
   a_coast_off: assert property (@(posedge sys_clk) disable iff (!rstN)
      coastOn && !tripOn && !tripLatch_r |=> !outputEnable && !$rose(faultAlarmOut))
      else $error("Coast left output on or alarmed.");
   a_reset_drop: assert property (@(posedge sys_clk) disable iff (!rstN)
      rstRise && !tripOn |=> !faultAlarmOut)
      else $error("Alarm reset did not drop alarm.");
   a_hold_clear: assert property (@(posedge sys_clk) disable iff (!rstN)
      !holdOn |=> !fwdHeld_r && !revHeld_r)
      else $error("Held run survived hold release.");
   a_hold_latch: assert property (@(posedge sys_clk) disable iff (!rstN)
      holdOn && fwdRise && !fwdHeld_r && !revHeld_r ##1 holdOn [*2] |-> fwdHeld_r)
      else $error("Forward run was not self held.");
   a_preset_pick: assert property (@(posedge sys_clk) disable iff (!rstN)
      presetIdx != 4'h0 && jogState_r != JS_JOGGING |=> freqRef == $past(presetFreq[presetIdx]))
      else $error("Preset frequency not selected.");
   a_motor_follow: assert property (@(posedge sys_clk) disable iff (!rstN)
      $changed(motorSelect) |=> motor2ActiveOut == $past(motorSelect))
      else $error("Motor-2 output did not follow switch.");
   a_mode_stopped: assert property (@(posedge sys_clk) disable iff (!rstN)
      jogState_r == JS_READY && !driveStopped |=> jogState_r != JS_NORMAL)
      else $error("Jog readiness left while running.");
   c_trip_reset: cover property (@(posedge sys_clk) disable iff (!rstN)
      tripLatch_r ##[1:50] rstFall);
   c_jog_run: cover property (@(posedge sys_clk) disable iff (!rstN)
      jogState_r == JS_READY ##1 jogState_r == JS_JOGGING);
   c_motor_two: cover property (@(posedge sys_clk) disable iff (!rstN)
      $rose(motor2ActiveOut));
endmodule

// >>> design/term_decoder_cfg.svh
// Constants for the drive terminal command decoder: bit positions, codes and timing.
`ifndef TERM_DECODER_CFG_SVH
`define TERM_DECODER_CFG_SVH
// =============================================================
// Function input positions within the terminal vector
// =============================================================
`define FN_PRESET0     0
`define FN_PRESET3     3
`define FN_RAMP        4
`define FN_HOLD        5
`define FN_COAST       6
`define FN_ALMRST      7
`define FN_TRIP        8
`define FN_JOG         9
`define FN_FREQSEL     10
`define FN_MOTORSEL    11
`define FN_COUNT       12
// Extra synchronised lines after the function block.
`define PIN_FWD        12
`define PIN_REV        13
`define PIN_KEYJOG     14
`define PIN_KEYRUN     15
`define PIN_COUNT      16
// =============================================================
// Sizes, codes and reset values
// =============================================================
`define PRESET_COUNT   15
`define FREQ_WIDTH     16
`define CODE_WIDTH     8
`define CODE_NONE      8'h00
`define CODE_EXT_TRIP  8'h09
`define MOTOR_RESET    1'b0
// =============================================================
// Timing
// =============================================================
`define CLK_MHZ        100
`define SYNC_SETTLE    4
`define JOG_SKEW_US    100000
`define JOG_SKEW_CYC   (`JOG_SKEW_US * `CLK_MHZ)
`endif

// >>> design/term_decoder_pkg.sv
// Types shared by the drive terminal command decoder files.
package term_decoder_pkg;
   // Acceleration and deceleration time pair.
   typedef struct packed {
      logic [15:0] accel;
      logic [15:0] decel;
   } ramp_t;
   // Run command towards the drive logic.
   typedef struct packed {
      logic run_forward;
      logic run_reverse;
   } run_cmd_t;
   // Jog state machine states.
   typedef enum logic [1:0] {
      JS_NORMAL  = 2'b00,
      JS_READY   = 2'b01,
      JS_JOGGING = 2'b10
   } jog_state_t;
endpackage

// >>> design/term_sync.sv
// Three-stage synchroniser for asynchronous terminal pins.
`timescale 1ns/1ns
module term_sync #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rstN,
   input  wire logic [W-1:0] raw,
   output logic      [W-1:0] level
);
   // =============================================================
   // Per-pin three flip-flop chain
   // =============================================================
   initial begin
      if (W < 1) $error("term_sync width must be positive.");
   end
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         logic s1, s2, s3;   // Stage one is read only by stage two.
         // The level moves only once stages two and three agree.
         always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               level[i] <= 1'b0;
            end else begin
               s1 <= raw[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  level[i] <= s3;
               end
            end
         end
      end
   endgenerate
endmodule

// >>> dv/switch_panel.sv
// Model of the switch panel and keypad that drive the terminal pins.
`timescale 1ns/1ns
module switch_panel (
   input  wire logic        sysClk,
   input  wire logic [15:0] want,
   output logic      [11:0] termPin,
   output logic             fwdPin,
   output logic             revPin,
   output logic             jogKeyPin,
   output logic             runKeyPin
);
   // =============================================================
   // Contacts
   // =============================================================
   // Contacts move at the falling edge, well away from the sampling edge.
   // Each level is held for many cycles, so pulses are never too short.
   always @(negedge sysClk) begin
      {runKeyPin, jogKeyPin, revPin, fwdPin, termPin} <= want;
   end
endmodule

// >>> dv/test_drive_terminal_command_decoder.sv
// Self-checking bench for the drive terminal command decoder.
`timescale 1ns/1ns
module test_drive_terminal_command_decoder;
   import term_decoder_pkg::*;
   // =============================================================
   // Stimulus and observed signals
   // =============================================================
   logic        sysClk = 1'b0;   // System clock.
   logic        arstN  = 1'b0;   // Reset, active low.
   logic [15:0] sw     = 16'h0100; // Wanted pin levels; trip pin idles high.
   logic [11:0] fa = 12'hFFF, fl = 12'h100; // Assignment and polarity.
   logic        rsd = 1'b1, stp = 1'b1; // Run source and standstill.
   logic [15:0] freqOne = 16'hA001, freqTwo = 16'hB002, jogFreq = 16'hC003; // Sources.
   logic [15:0] pf [1:15];        // Preset table.
   logic [11:0] tp;
   logic        fw, rv, kj, kr;
   logic [15:0] freqRef;
   ramp_t       rampActive;
   run_cmd_t    runCmd;
   logic        outputEnable, faultAlarmOut, alarmHold, jogReady, jogActive;
   logic        motorSelect, motor2ActiveOut;
   logic [7:0]  alarmCode;
   int          failures = 0, checkCount = 0;
   always #5 sysClk = ~sysClk;
   switch_panel i_switch_panel (.sysClk(sysClk), .want(sw), .termPin(tp), .fwdPin(fw),
      .revPin(rv), .jogKeyPin(kj), .runKeyPin(kr));
   // A short skew window keeps the run brief.
   term_decoder #(.SKEW_CYC(20)) i_term_decoder (.sys_clk(sysClk), .arst_n(arstN),
      .termPin(tp), .runForwardPin(fw), .runReversePin(rv), .keyJogPin(kj),
      .keyRunPin(kr), .funcAssigned(fa), .funcActiveLow(fl), .runSourceDigital(rsd),
      .driveStopped(stp), .presetFreq(pf), .freqSourceOne(freqOne),
      .freqSourceTwo(freqTwo), .jogFrequency(jogFreq), .rampOne(32'h00110022),
      .rampTwo(32'h00330044), .jogRamp(32'h00550066), .freqRef(freqRef),
      .rampActive(rampActive), .runCmd(runCmd), .outputEnable(outputEnable),
      .faultAlarmOut(faultAlarmOut), .alarmCode(alarmCode), .alarmHold(alarmHold),
      .jogReady(jogReady), .jogActive(jogActive), .motorSelect(motorSelect),
      .motor2ActiveOut(motor2ActiveOut));
   // =============================================================
   // Tasks
   // =============================================================
   // Compares one observed value with its expectation.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Sets the pin levels, then waits past the six-edge input latency.
   task automatic drive(input logic [15:0] v);
      @(posedge sysClk);
      #1 sw = v;
      repeat (7) @(posedge sysClk);
      #1;
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      $display("checks %0d failures %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // A hang counts as a mismatch.
   initial begin
      repeat (5000) @(posedge sysClk);
      failures++;
      end_sim();
   end
   // =============================================================
   // Scenarios
   // =============================================================
   initial begin
      for (int n = 1; n <= 15; n++) pf[n] = 16'h1000 + n[15:0];
      repeat (3) @(posedge sysClk);
      @(negedge sysClk) arstN = 1'b1;
      chk(outputEnable, 0);
      drive(sw);
      chk(outputEnable, 1);
      // Every select code, including zero.
      for (int i = 0; i < 16; i++) begin
         drive({sw[15:4], i[3:0]});
         chk(freqRef, (i == 0) ? 16'hA001 : 16'h1000 + i[15:0]);
      end
      // A new value on source one must reach the reference.
      @(negedge sysClk) freqOne = 16'hA0F1;
      drive(sw & 16'hFFF0);
      chk(freqRef, 16'hA0F1);
      drive(sw | 16'h0400);
      chk(freqRef, 16'hB002);
      drive(sw & ~16'h0400 | 16'h0010);
      chk(rampActive, 32'h00330044);
      @(negedge sysClk) fa[4] = 1'b0;
      drive(sw);
      chk(rampActive, 32'h00110022);
      // Hold contact closed but unassigned: the run must not stick.
      @(negedge sysClk) fa[5] = 1'b0;
      drive(sw & ~16'h0010 | 16'h1020);
      chk(runCmd, 2'b10);
      drive(sw & ~16'h1000);
      chk(runCmd, 2'b00);
      @(negedge sysClk) fa[5] = 1'b1;
      drive(sw | 16'h1000);
      drive(sw & ~16'h1000);
      chk(runCmd, 2'b10);
      drive(sw & ~16'h0020);
      chk(runCmd, 2'b00);
      drive(sw | 16'h0040);
      chk({outputEnable, faultAlarmOut}, 2'b00);
      drive(sw & ~16'h0040);
      @(negedge sysClk) fl[6] = 1'b1;
      drive(sw);
      chk(outputEnable, 0);
      @(negedge sysClk) fl[6] = 1'b0;
      drive(sw & ~16'h0100);
      chk({outputEnable, faultAlarmOut, alarmCode}, 10'h109);
      drive(sw | 16'h0100);
      chk({faultAlarmOut, alarmHold}, 2'b11);
      // The reset contact is held for several cycles.
      drive(sw | 16'h0080);
      chk({faultAlarmOut, alarmCode}, 9'h009);
      drive(sw & ~16'h0080);
      chk({outputEnable, alarmHold, alarmCode}, 10'h200);
      // Inverted trip polarity: a closed contact now trips.
      @(negedge sysClk) fl[8] = 1'b0;
      drive(sw);
      chk(faultAlarmOut, 1);
      @(negedge sysClk) fl[8] = 1'b1;
      drive(sw | 16'h0080);
      drive(sw & ~16'h0080);
      chk(outputEnable, 1);
      drive(sw | 16'h4000);
      drive(sw & ~16'h4000);
      chk(jogReady, 0);
      @(negedge sysClk) rsd = 1'b0;
      drive(sw | 16'h4000);
      drive(sw & ~16'h4000);
      chk(jogReady, 1);
      drive(sw | 16'h8000);
      chk({jogActive, runCmd}, 3'b110);
      drive(sw & ~16'h8000);
      chk(jogActive, 0);
      drive(sw | 16'h4000);
      drive(sw & ~16'h4000);
      chk(jogReady, 0);
      drive(sw | 16'h0200);
      chk(jogReady, 1);
      drive(sw | 16'h1000);
      chk(jogActive, 1);
      chk(freqRef, 16'hC003);
      chk(rampActive, 32'h00550066);
      drive(sw & ~16'h1000);
      @(negedge sysClk) stp = 1'b0;
      drive(sw & ~16'h0200);
      chk(jogReady, 1);
      drive(sw | 16'h0800);
      chk(motorSelect, 0);
      @(negedge sysClk) stp = 1'b1;
      drive(sw);
      chk({jogReady, motorSelect, motor2ActiveOut}, 3'b011);
      // Run first, jog inside the skew window: jogging starts while running.
      @(negedge sysClk) stp = 1'b0;
      drive(sw | 16'h1000);
      chk({jogActive, runCmd}, 3'b010);
      drive(sw | 16'h0200);
      chk(jogActive, 1);
      drive(sw & ~16'h1200);
      @(negedge sysClk) stp = 1'b1;
      drive(sw);
      chk(jogReady, 0);
      // Jog after the window has closed: the ordinary run goes on.
      @(negedge sysClk) stp = 1'b0;
      drive(sw | 16'h1000);
      drive(sw);
      drive(sw);
      drive(sw | 16'h0200);
      chk({jogReady, runCmd}, 3'b010);
      end_sim();
   end
endmodule
